/* logic/stc_pkg.sv */
// Shared constants and types of the SYSREF timing calibration control block.
package stc_pkg;
  localparam int ADDR_W = 15;
  localparam logic [14:0] A_NOISE = 15'h02a2;
  localparam logic [14:0] A_EN = 15'h02b0;
  localparam logic [14:0] A_CFG = 15'h02b1;
  localparam logic [14:0] A_STAT0 = 15'h02b2;
  localparam logic [14:0] A_STAT1 = 15'h02b3;
  localparam logic [14:0] A_STAT2 = 15'h02b4;
  localparam logic [14:0] A_TAD0 = 15'h02b5;
  localparam logic [14:0] A_TAD1 = 15'h02b6;
  localparam logic [14:0] A_TAD2 = 15'h02b7;
  localparam int NS_DIG_BIT = 5;
  localparam int NS_CLK_BIT = 4;
  localparam int EN_BIT = 0;
  localparam int AVG_LSB = 2;
  localparam int ACC_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam logic [7:0] NOISE_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h05;
  localparam logic [23:0] TAD_RST = 24'h000000;
  localparam int SPI_HDR_BITS = 16;
  localparam int SPI_FRAME_BITS = 24;
  localparam logic [8:0] CNT_BASE = 9'h004;
  localparam logic [3:0] EXP_OFS = 4'h2;
  localparam int CAL_MUL_A = 384;
  localparam int CAL_MUL_B = 19;
  localparam int CAL_BASE = CAL_MUL_A * CAL_MUL_B;
  localparam int PER_LIM0 = 128;
  localparam int PER_LIM1 = 1664;
  localparam int PER_LIM2 = 7808;
  localparam int PER_LIM3 = 32384;
  localparam int DLY_W = 17;
  localparam int GAP_W = 16;
  localparam int TMO_W = 29;
  localparam int FRAC_W = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_ACCUM, ST_CALC} stc_state_e;
endpackage

/* logic/stc_if.sv */
// Interfaces between the calibration top and its serial port and SYSREF meter.
`timescale 1ns/100ps
interface stc_reg_if;
  logic wr;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master(output wr, addr, wdata, input rdata);
  modport slave(input wr, addr, wdata, output rdata);
endinterface

interface stc_meas_if;
  logic lvl;
  logic edge_p;
  logic [15:0] gap;
  modport src(output lvl, edge_p, gap);
  modport snk(input lvl, edge_p, gap);
endinterface

/* logic/stc_spi_slave.sv */
// Serial control port: 24-bit frames of read flag, 15-bit address and one data byte.
`timescale 1ns/100ps
module stc_spi_slave
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo_q,
  output logic spi_sdo_oe_q,
  stc_reg_if.master rbus
);
  logic [2:0] sclk_s;
  logic [1:0] csn_s;
  logic [1:0] sdi_s;
  logic [4:0] cnt_q;
  logic [22:0] sh_q;
  logic rd_q;
  logic [14:0] addr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_s <= 3'h0;
      csn_s <= 2'h3;
      sdi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      csn_s <= {csn_s[0], spi_csn};
      sdi_s <= {sdi_s[0], spi_sdi};
    end
  end

  assign rise = sclk_s[1] & ~sclk_s[2];
  assign fall = ~sclk_s[1] & sclk_s[2];

  always_ff @(posedge clk) begin
    if (sys_rst || csn_s[1]) begin
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (rise && cnt_q < 5'(SPI_FRAME_BITS)) begin
        sh_q <= {sh_q[21:0], sdi_s[1]};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'(SPI_HDR_BITS - 1)) begin
          addr_q <= {sh_q[13:0], sdi_s[1]};
          rd_q <= sh_q[14];
        end
        if (cnt_q == 5'(SPI_FRAME_BITS - 1) && !rd_q) begin
          wr_q <= 1'b1;
          wdata_q <= {sh_q[6:0], sdi_s[1]};
        end
      end
    end
  end

  // Read data is driven on the falling edge so the host can sample it on the next rising edge.
  always_ff @(posedge clk) begin
    if (sys_rst || csn_s[1]) begin
      spi_sdo_q <= 1'b0;
      spi_sdo_oe_q <= 1'b0;
    end else if (fall && rd_q && cnt_q >= 5'(SPI_HDR_BITS) && cnt_q < 5'(SPI_FRAME_BITS)) begin
      spi_sdo_q <= rbus.rdata[3'(5'(SPI_FRAME_BITS - 1) - cnt_q)];
      spi_sdo_oe_q <= 1'b1;
    end
  end

  assign rbus.wr = wr_q;
  assign rbus.addr = addr_q;
  assign rbus.wdata = wdata_q;
endmodule

/* logic/stc_sysref_meter.sv */
// SYSREF pin synchroniser, rising edge detector and edge-to-edge gap counter.
`timescale 1ns/100ps
module stc_sysref_meter
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sysref,
  stc_meas_if.src meas
);
  logic [2:0] sync_q;
  logic edge_q;
  logic [15:0] gap_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_q <= 3'h0;
      edge_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], sysref};
      edge_q <= sync_q[1] & ~sync_q[2];
    end
  end

  // The gap saturates so that a lost SYSREF still reads as an over-long period.
  always_ff @(posedge clk) begin
    if (sys_rst || edge_q) begin
      gap_q <= 16'h0000;
    end else if (gap_q != 16'hffff) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  assign meas.lvl = sync_q[2];
  assign meas.edge_p = edge_q;
  assign meas.gap = gap_q;
endmodule

/* logic/stc_cal_top.sv */
// SYSREF timing calibration control: registers, calibration sequencer and delay select.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////
module stc_cal_top
  import stc_pkg::*;
#(
  parameter int CAL_BASE_P = CAL_BASE,
  parameter int PER_LIM2_P = PER_LIM2,
  parameter int PER_LIM3_P = PER_LIM3
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic sysref,
  output logic digital_supply_noise_suppress,
  output logic clock_supply_noise_suppress,
  output logic [16:0] dev_clk_delay,
  output logic cal_failed
);
  stc_reg_if rbus();
  stc_meas_if meas();

  stc_spi_slave u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_csn(spi_csn),
    .spi_sdi(spi_sdi),
    .spi_sdo_q(spi_sdo),
    .spi_sdo_oe_q(spi_sdo_oe),
    .rbus(rbus.master)
  );

  stc_sysref_meter u_meter (
    .clk(clk),
    .sys_rst(sys_rst),
    .sysref(sysref),
    .meas(meas.src)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  logic [7:0] noise_q;
  logic [7:0] en_q;
  logic [7:0] cfg_q;
  logic [23:0] tad_q;
  logic en_prev_q;
  logic start_w;
  logic busy_w;
  stc_state_e state_q;
  logic [1:0] lat_avg_q;
  logic [1:0] lat_acc_q;
  logic [8:0] avg_cnt_q;
  logic [8:0] acc_cnt_q;
  logic [16:0] sum_q;
  logic [28:0] tmo_q;
  logic armed_q;
  logic done_q;
  logic fail_q;
  logic complete_q;
  logic [16:0] result_q;
  logic [16:0] dly_q;
  logic [8:0] avg_tot;
  logic [8:0] acc_len;
  logic [3:0] expo;
  logic [28:0] bound;
  logic [15:0] per_lim;
  logic over_w;
  logic [16:0] frac_w;
  logic [23:0] stat_w;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      noise_q <= NOISE_RST;
      en_q <= EN_RST;
      cfg_q <= CFG_RST;
      tad_q <= TAD_RST;
    end else if (rbus.wr) begin
      unique case (rbus.addr)
        A_NOISE: noise_q <= rbus.wdata;
        A_EN: en_q <= rbus.wdata;
        A_CFG: cfg_q <= rbus.wdata;
        A_TAD0: tad_q[7:0] <= rbus.wdata;
        A_TAD1: tad_q[15:8] <= rbus.wdata;
        A_TAD2: tad_q[23:16] <= rbus.wdata;
        default: ;
      endcase
    end
  end

  // Status bytes are computed by hardware, so writes to them are dropped.
  assign stat_w = {6'h00, complete_q, result_q};

  always_comb begin
    unique case (rbus.addr)
      A_NOISE: rbus.rdata = noise_q;
      A_EN: rbus.rdata = en_q;
      A_CFG: rbus.rdata = cfg_q;
      A_STAT0: rbus.rdata = stat_w[7:0];
      A_STAT1: rbus.rdata = stat_w[15:8];
      A_STAT2: rbus.rdata = stat_w[23:16];
      A_TAD0: rbus.rdata = tad_q[7:0];
      A_TAD1: rbus.rdata = tad_q[15:8];
      A_TAD2: rbus.rdata = tad_q[23:16];
      default: rbus.rdata = 8'h00;
    endcase
  end

  assign digital_supply_noise_suppress = noise_q[NS_DIG_BIT];
  assign clock_supply_noise_suppress = noise_q[NS_CLK_BIT];

  //////////////////////////////////////////////////////////////////////////////////////////
  assign start_w = en_q[EN_BIT] & ~en_prev_q;
  assign busy_w = state_q != ST_IDLE;
  assign avg_tot = CNT_BASE << {lat_avg_q, 1'b0};
  assign acc_len = CNT_BASE << {lat_acc_q, 1'b0};
  assign expo = 4'(lat_avg_q) + 4'(lat_acc_q) + EXP_OFS;
  assign bound = 29'(CAL_BASE_P) << {expo, 1'b0};
  assign over_w = armed_q && meas.gap > per_lim;
  assign frac_w = sum_q << 5'(5'(FRAC_W) - {expo, 1'b0});

  // The period limit follows the latched accumulation length, not the live register.
  always_comb begin
    unique case (lat_acc_q)
      2'h0: per_lim = 16'(PER_LIM0);
      2'h1: per_lim = 16'(PER_LIM1);
      2'h2: per_lim = 16'(PER_LIM2_P);
      2'h3: per_lim = 16'(PER_LIM3_P);
    endcase
  end

  // The previous enable value turns the start into one pulse on the 0-to-1 change only.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_q[EN_BIT];
    end
  end

  // A write to the configuration while busy cannot change the running sequence.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_avg_q <= CFG_RST[AVG_LSB +: 2];
      lat_acc_q <= CFG_RST[ACC_LSB +: 2];
    end else if (start_w) begin
      lat_avg_q <= cfg_q[AVG_LSB +: 2];
      lat_acc_q <= cfg_q[ACC_LSB +: 2];
    end
  end

  // Enable low is tested first, so a disable aborts the run whatever else happens in that cycle.
  always_ff @(posedge clk) begin
    if (sys_rst || !en_q[EN_BIT]) begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      armed_q <= 1'b0;
      tmo_q <= 29'h0;
    end else if (start_w) begin
      state_q <= ST_SEEK;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      armed_q <= 1'b0;
      tmo_q <= 29'h0;
      avg_cnt_q <= 9'h000;
      sum_q <= 17'h00000;
    end else if (busy_w) begin
      tmo_q <= tmo_q + 29'h1;
      if (meas.edge_p) begin
        armed_q <= 1'b1;
      end
      if (over_w || tmo_q >= bound - 29'h1) begin
        state_q <= ST_IDLE;
        fail_q <= 1'b1;
      end else begin
        unique case (state_q)
          ST_SEEK: begin
            if (meas.edge_p) begin
              state_q <= ST_ACCUM;
              acc_cnt_q <= 9'h000;
            end
          end
          ST_ACCUM: begin
            sum_q <= sum_q + 17'(meas.lvl);
            acc_cnt_q <= acc_cnt_q + 9'h001;
            if (acc_cnt_q == acc_len - 9'h001) begin
              avg_cnt_q <= avg_cnt_q + 9'h001;
              state_q <= (avg_cnt_q == avg_tot - 9'h001) ? ST_CALC : ST_SEEK;
            end
          end
          ST_CALC: begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // A full-scale sum saturates rather than wrapping to a zero delay.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_q <= 17'h00000;
    end else if (state_q == ST_CALC && en_q[EN_BIT]) begin
      result_q <= frac_w[FRAC_W] ? 17'h1fffe : {frac_w[15:0], 1'b0};
    end
  end

  // The delay output is registered so that the pin never glitches while its source switches.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      complete_q <= 1'b0;
      dly_q <= 17'h00000;
      cal_failed <= 1'b0;
    end else begin
      complete_q <= en_q[EN_BIT] & done_q;
      dly_q <= en_q[EN_BIT] ? result_q : tad_q[16:0];
      cal_failed <= fail_q;
    end
  end

  assign dev_clk_delay = dly_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_noise;
    rbus.wr && rbus.addr == A_NOISE;
  endsequence

  sequence s_leave_acc;
    $past(state_q == ST_ACCUM) && (state_q == ST_SEEK || state_q == ST_CALC);
  endsequence

  sequence s_edge_seen;
    state_q == ST_SEEK && meas.edge_p && en_q[EN_BIT] && !over_w && tmo_q < bound - 29'h1;
  endsequence

  sequence s_cal_finish;
    state_q == ST_CALC && en_q[EN_BIT] && !over_w && tmo_q < bound - 29'h1;
  endsequence

  dig_noise_a: assert property (s_wr_noise |=> digital_supply_noise_suppress == $past(rbus.wdata[NS_DIG_BIT]))
    else $error("digital supply suppression does not follow the write");
  clk_noise_a: assert property (s_wr_noise |=> clock_supply_noise_suppress == $past(rbus.wdata[NS_CLK_BIT]))
    else $error("clock supply suppression does not follow the write");
  manual_path_a: assert property (!en_q[EN_BIT] |=> dev_clk_delay == $past(tad_q[16:0]))
    else $error("delay output ignores the manual register");
  auto_path_a: assert property (en_q[EN_BIT] |=> dev_clk_delay == $past(result_q))
    else $error("delay output not taken from calibration");
  cal_start_a: assert property ($rose(busy_w) |-> $past(en_q[EN_BIT]) && !$past(en_prev_q))
    else $error("sequence started without an enable edge");
  avg_count_a: assert property (state_q == ST_CALC |-> avg_cnt_q == avg_tot)
    else $error("wrong number of averages");
  accum_len_a: assert property (s_leave_acc |-> $past(acc_cnt_q) == acc_len - 9'h001)
    else $error("accumulation length differs from setting");
  cal_length_a: assert property (state_q == ST_CALC |-> tmo_q >= 29'(avg_tot) * 29'(acc_len))
    else $error("calibration shorter than averaging times accumulation");
  period_fail_a: assert property (busy_w && en_q[EN_BIT] && !start_w && over_w |=> fail_q ##1 cal_failed)
    else $error("over-long SYSREF period not flagged");
  max_time_a: assert property (busy_w |-> tmo_q < bound)
    else $error("calibration exceeded its time bound");
  done_flag_a: assert property (complete_q |-> $past(en_q[EN_BIT] && done_q))
    else $error("completion flag without enable and completion");
  result_hold_a: assert property (complete_q && $past(complete_q) |-> $stable(result_q))
    else $error("result changed while complete");
  cfg_latch_a: assert property (busy_w && !start_w |=> $stable({lat_avg_q, lat_acc_q}))
    else $error("configuration changed during a running sequence");

  // Sequencer steps: start, abort, the edge that opens a window, finish and a lasting failure.
  start_seek_a: assert property (start_w |=> state_q == ST_SEEK && !fail_q && !done_q)
    else $error("start did not open a fresh sequence");
  disable_clear_a: assert property (!en_q[EN_BIT] |=> state_q == ST_IDLE && !done_q && !fail_q)
    else $error("enable low did not abort the sequence");
  seek_wait_a: assert property (state_q == ST_SEEK && !meas.edge_p |=> state_q != ST_ACCUM)
    else $error("accumulation began without a SYSREF edge");
  acc_start_a: assert property (s_edge_seen |=> state_q == ST_ACCUM && acc_cnt_q == 9'h000)
    else $error("SYSREF edge did not open an accumulation window");
  done_next_a: assert property (s_cal_finish |=> done_q && state_q == ST_IDLE)
    else $error("sequence did not complete after the last average");
  flag_follow_a: assert property (en_q[EN_BIT] && done_q |=> complete_q)
    else $error("completion flag missing after completion");
  fail_hold_a: assert property (fail_q && en_q[EN_BIT] |=> fail_q)
    else $error("failure cleared while enable stays high");
endmodule

/* tb/stc_host_model.sv */
// Host model: serial control port master and SYSREF source.
`timescale 1ns/100ps
module stc_host_model (
  input wire logic clk,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_sdi,
  input wire logic spi_sdo,
  output logic sysref
);
  // Eight clocks per half period keeps well clear of the port's synchroniser limit.
  localparam int HALF = 8;
  int sr_per = 0;
  int sr_cnt = 0;

  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
    sysref = 1'b0;
  end

  // The host never runs a converter calibration, so enabling is always allowed.
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] frm;
    frm = {rd, addr, wd};
    rdat = 8'h00;
    @(posedge clk);
    spi_csn <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      spi_sdi <= frm[i];
      repeat (HALF) @(posedge clk);
      if (i < 8) begin
        rdat[i] = spi_sdo;
      end
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spi_csn <= 1'b1;
    spi_sdi <= ~spi_sdi;
    repeat (12) @(posedge clk);
  endtask

  // A period above the accumulation limit is produced only when the bench asks for it.
  always @(posedge clk) begin
    if (sr_per == 0) begin
      sr_cnt <= 0;
      sysref <= 1'b0;
    end else begin
      sr_cnt <= (sr_cnt + 1 >= sr_per) ? 0 : sr_cnt + 1;
      sysref <= (sr_cnt < sr_per / 2);
    end
  end
endmodule

/* tb/sysref_timing_calibration_ctrl_tb.sv */
// Testbench of the SYSREF timing calibration control block.
`timescale 1ns/100ps
module sysref_timing_calibration_ctrl_tb;
  import stc_pkg::*;
  localparam int CBASE = 64;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic spi_sclk;
  logic spi_csn;
  logic spi_sdi;
  logic spi_sdo;
  logic sdo_oe;
  logic oe_seen = 1'b0;
  logic sysref;
  logic dig_ns;
  logic clk_ns;
  logic [16:0] dly;
  logic cal_failed;
  logic [7:0] rb;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int t_a;
  int t_b;
  int t_c;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  always @(posedge clk) begin
    if (sdo_oe) begin
      oe_seen <= 1'b1;
    end
  end

  stc_host_model u_host (.clk(clk), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .sysref(sysref));

  stc_cal_top #(.CAL_BASE_P(CBASE)) u_dut (.clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
    .spi_csn(spi_csn), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(sdo_oe), .sysref(sysref),
    .digital_supply_noise_suppress(dig_ns), .clock_supply_noise_suppress(clk_ns),
    .dev_clk_delay(dly), .cal_failed(cal_failed));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.xfer(1'b0, a, d, r);
  endtask

  task automatic rchk(input string what, input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_host.xfer(1'b1, a, 8'h00, r);
    check(what, {9'h000, r}, {9'h000, exp});
  endtask

  // Configuration is written before the enable goes high and written again with cfg_late just after it.
  task automatic cal_run(input logic [7:0] cfg, input logic [7:0] cfg_late, output int dur);
    int t0;
    logic [7:0] r;
    wr(A_CFG, cfg);
    wr(A_EN, 8'h01);
    t0 = cyc;
    wr(A_CFG, cfg_late);
    r = 8'h00;
    for (int i = 0; i < 60 && r[1] !== 1'b1; i++) begin
      u_host.xfer(1'b1, A_STAT2, 8'h00, r);
    end
    dur = cyc - t0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("delay after reset", dly, 17'h00000);
    check("suppress after reset", {15'h0000, dig_ns, clk_ns}, 17'h00000);
    check("no drive after reset", {15'h0000, oe_seen, sdo_oe}, 17'h00000);
    rchk("noise reset", A_NOISE, NOISE_RST);
    rchk("enable reset", A_EN, EN_RST);
    rchk("config reset", A_CFG, 8'h05);
    check("drive during read only", {15'h0000, oe_seen, sdo_oe}, 17'h00002);
    // Each suppress bit is driven alone so that swapped outputs show up.
    wr(A_NOISE, 8'h20);
    check("digital suppress", {15'h0000, dig_ns, clk_ns}, 17'h00002);
    wr(A_NOISE, 8'h10);
    check("clock suppress", {15'h0000, dig_ns, clk_ns}, 17'h00001);
    wr(A_NOISE, 8'hff);
    rchk("noise readback", A_NOISE, 8'hff);
    wr(15'h0300, 8'h5a);
    rchk("unmapped read", 15'h0300, 8'h00);
    wr(A_STAT0, 8'h55);
    rchk("status not writable", A_STAT0, 8'h00);
    wr(A_TAD0, 8'h34);
    wr(A_TAD1, 8'h12);
    wr(A_TAD2, 8'h03);
    check("manual delay", dly, 17'h11234);
    // A SYSREF period above the limit of the shortest accumulation must fail.
    @(posedge clk);
    u_host.sr_per <= 200;
    wr(A_CFG, 8'h00);
    wr(A_EN, 8'h01);
    repeat (1500) @(posedge clk);
    check("long period fails", {16'h0000, cal_failed}, 17'h00001);
    rchk("no completion on fail", A_STAT2, 8'h00);
    wr(A_EN, 8'h00);
    check("fail cleared", {16'h0000, cal_failed}, 17'h00000);
    check("manual after disable", dly, 17'h11234);
    // Shortest run: four averages of four samples each.
    @(posedge clk);
    u_host.sr_per <= 40;
    cal_run(8'h00, 8'h00, t_a);
    check("short run bound", {16'h0000, t_a <= CBASE * 16}, 17'h00001);
    check("calibrated delay", dly, 17'h1fffe);
    check("no failure", {16'h0000, cal_failed}, 17'h00000);
    rchk("result low", A_STAT0, 8'hfe);
    rchk("result mid", A_STAT1, 8'hff);
    rchk("result high and flag", A_STAT2, 8'h03);
    wr(A_TAD1, 8'h77);
    check("manual ignored", dly, 17'h1fffe);
    // Rewriting the enable with a long setting must not restart the sequence.
    wr(A_CFG, 8'h0f);
    wr(A_EN, 8'h01);
    rchk("no restart on rewrite", A_STAT2, 8'h03);
    wr(A_EN, 8'h00);
    // The flag drops on disable while the stale result bit 16 still reads back.
    rchk("flag cleared", A_STAT2, 8'h01);
    check("manual restored", dly, 17'h17734);
    // The late configuration write would take far beyond the bound if it were used.
    cal_run(8'h08, 8'h0f, t_b);
    check("latched run bound", {16'h0000, t_b <= CBASE * 256}, 17'h00001);
    check("more averaging is longer", {16'h0000, t_b > t_a}, 17'h00001);
    rchk("long run done", A_STAT2, 8'h03);
    wr(A_EN, 8'h00);
    // A period above the shortest limit passes with the next accumulation length.
    @(posedge clk);
    u_host.sr_per <= 200;
    cal_run(8'h01, 8'h00, t_c);
    check("longer period accepted", {16'h0000, cal_failed}, 17'h00000);
    check("medium run bound", {16'h0000, t_c <= CBASE * 64}, 17'h00001);
    rchk("medium run done", A_STAT2, 8'h03);
    wr(A_EN, 8'h00);
    stop_test();
  end
endmodule
